// ===== ccr_pkg.sv
// camera control register bank: offsets, field positions, reset values
// assumes a 12-bit apb byte address below the camera register base
package ccr_pkg;

    localparam logic [47:0] CCR_BASE_ADDR   = 48'hffff_f0f0_0000;
    localparam int          ADDR_W          = 12;
    localparam int          NUM_FEAT        = 11;
    localparam int          VAL_W           = 12;

    // function control offsets
    localparam logic [11:0] OFS_RATE        = 12'h600;
    localparam logic [11:0] OFS_MODE        = 12'h604;
    localparam logic [11:0] OFS_FORMAT      = 12'h608;
    localparam logic [11:0] OFS_CHAN_SPEED  = 12'h60c;
    localparam logic [11:0] OFS_POWER       = 12'h610;
    localparam logic [11:0] OFS_STREAM      = 12'h614;
    localparam logic [11:0] OFS_SINGLE      = 12'h61c;

    // feature control offsets, index order used throughout
    localparam int FI_BRIGHT  = 0;
    localparam int FI_EXPO    = 1;
    localparam int FI_SHARP   = 2;
    localparam int FI_BAL     = 3;
    localparam int FI_SAT     = 4;
    localparam int FI_GAMMA   = 5;
    localparam int FI_BACKLT  = 6;
    localparam int FI_GAIN    = 7;
    localparam int FI_APERT   = 8;
    localparam int FI_FOCUS   = 9;
    localparam int FI_ZOOM    = 10;
    localparam logic [11:0] FEAT_OFS [NUM_FEAT] = '{
        12'h800, 12'h804, 12'h508, 12'h80c, 12'h814, 12'h818,
        12'h81c, 12'h820, 12'h824, 12'h828, 12'h580};

    // field positions; quadlet bit 0 is the msb, so bit n sits at 31-n
    localparam int SEL_MSB      = 31;
    localparam int SEL_LSB      = 29;
    localparam int CHAN_MSB     = 31;
    localparam int CHAN_LSB     = 28;
    localparam int SPEED_MSB    = 25;
    localparam int SPEED_LSB    = 24;
    localparam int CTRL_BIT     = 31;
    localparam int FB_PRESENT   = 31;
    localparam int FB_ON        = 25;
    localparam int FB_AUTO      = 24;
    localparam int U_MSB        = 23;
    localparam int U_LSB        = 12;
    localparam int VAL_MSB      = 11;
    localparam int VAL_LSB      = 0;

    // transmit speed codes
    localparam logic [1:0] SPEED_S100 = 2'h0;
    localparam logic [1:0] SPEED_S200 = 2'h1;
    localparam logic [1:0] SPEED_S400 = 2'h2;

    // reset values
    localparam logic [2:0]       RST_SEL    = 3'h0;
    localparam logic [3:0]       RST_CHAN   = 4'h0;
    localparam logic [1:0]       RST_SPEED  = SPEED_S100;
    localparam logic             RST_CTRL   = 1'b0;
    localparam logic [VAL_W-1:0] RST_VAL    = 12'h000;
    localparam logic             RST_ON     = 1'b1;
    localparam logic             RST_AUTO   = 1'b0;

    typedef struct packed {
        logic [2:0]              rate;
        logic [2:0]              mode;
        logic [2:0]              format;
        logic [3:0]              chan;
        logic [1:0]              speed;
        logic                    power;
        logic                    stream;
        logic                    single;
        logic [NUM_FEAT-1:0]     on;
        logic [NUM_FEAT-1:0]     auto;
        logic [NUM_FEAT*VAL_W-1:0] value;
        logic [VAL_W-1:0]        uValue;
        logic [31:0]             rdata;
    } ccr_state_t;

endpackage : ccr_pkg

// ===== ccr_register_bank.sv
// camera function and feature control registers behind an apb slave
// assumes frameSent comes from the video datapath on the same clock
`timescale 1ns/10ps

// Behaviour
// - top three bits of frame rate register select one of eight rates
// - top three bits of video mode register select one of eight modes
// - top three bits of video format register select one of eight formats
// - channel/speed bits 0-3 give channel 0-15; bits 4-5 reserved
// - channel/speed bits 6-7 give speed: 0 s100, 1 s200, 2 s400
// - power bit 0 turns camera on or off and drives sensor power pin
// - stream enable bit 0 starts or stops continuous video transmission
// - single-frame bit sends one frame, then clears itself after it went out
// - single-frame request ignored while streaming is enabled
// - function control registers at 600h-61Ch; 618h, 620h-624h reserved
// - feature registers at 800h-828h; 82Ch-87Ch and 884h-8FCh reserved
// - feature bit 0 shows availability matching the inquiry presence bit
// - feature bit 6 sets and reads on/off; only features set in ON_OFF_CAP can switch (none by default)
// - feature bit 7 selects manual or auto; reads back the mode
// - feature bits 20-31 hold value; writes dropped in auto mode
// - white balance holds U in bits 8-19, V in 20-31; auto drops writes
// - the shutter slot controls backlight compensation
// - sharpness sits at 508h and zoom at 580h
module ccr_register_bank
    import ccr_pkg::*;
#(
    parameter logic [NUM_FEAT-1:0] PRESENT_MASK = 11'h0ff,
    parameter logic [NUM_FEAT-1:0] ON_OFF_CAP   = 11'h000
)
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      frameSent,
    output logic      [2:0]                frameRate,
    output logic      [2:0]                videoMode,
    output logic      [2:0]                videoFormat,
    output logic      [3:0]                isoChannel,
    output logic      [1:0]                isoSpeed,
    output logic                           sensorPower,
    output logic                           streamEnable,
    output logic                           singleFrameReq,
    output logic      [NUM_FEAT-1:0]       featureOn,
    output logic      [NUM_FEAT-1:0]       featureAuto,
    output logic      [NUM_FEAT*VAL_W-1:0] featureValue,
    output logic      [VAL_W-1:0]          balanceU
);

    ccr_state_t state_reg;
    ccr_state_t state_next;

    logic readSetup;
    logic writeAccess;

    // zero wait states: read data is captured in the setup cycle
    assign readSetup   = psel & ~penable & ~pwrite;
    assign writeAccess = psel & penable & pwrite;

    function automatic logic [31:0] read_word(input ccr_state_t s,
                                              input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            OFS_RATE:       w[SEL_MSB:SEL_LSB] = s.rate;
            OFS_MODE:       w[SEL_MSB:SEL_LSB] = s.mode;
            OFS_FORMAT:     w[SEL_MSB:SEL_LSB] = s.format;
            OFS_CHAN_SPEED:
            begin
                w[CHAN_MSB:CHAN_LSB]   = s.chan;
                w[SPEED_MSB:SPEED_LSB] = s.speed;
            end
            OFS_POWER:      w[CTRL_BIT] = s.power;
            OFS_STREAM:     w[CTRL_BIT] = s.stream;
            OFS_SINGLE:     w[CTRL_BIT] = s.single;
            default:        w = 32'h0000_0000;
        endcase
        for (int i = 0; i < NUM_FEAT; i++)
        begin
            if (a == FEAT_OFS[i])
            begin
                w[FB_PRESENT]       = PRESENT_MASK[i];
                w[FB_ON]            = s.on[i];
                w[FB_AUTO]          = s.auto[i];
                w[VAL_MSB:VAL_LSB]  = s.value[i*VAL_W +: VAL_W];
                if (i == FI_BAL)
                    w[U_MSB:U_LSB] = s.uValue;
            end
        end
        return w;
    endfunction : read_word

    always_comb
    begin
        state_next = state_reg;
        if (readSetup)
            state_next.rdata = read_word(state_reg, paddr);

        // completion clears first so a same-cycle write of 1 wins
        if (frameSent && state_reg.single)
            state_next.single = 1'b0;

        if (writeAccess)
        begin
            unique case (paddr)
                OFS_RATE:   state_next.rate   = pwdata[SEL_MSB:SEL_LSB];
                OFS_MODE:   state_next.mode   = pwdata[SEL_MSB:SEL_LSB];
                OFS_FORMAT: state_next.format = pwdata[SEL_MSB:SEL_LSB];
                OFS_CHAN_SPEED:
                begin
                    state_next.chan  = pwdata[CHAN_MSB:CHAN_LSB];
                    state_next.speed = pwdata[SPEED_MSB:SPEED_LSB];
                end
                OFS_POWER:  state_next.power  = pwdata[CTRL_BIT];
                OFS_STREAM: state_next.stream = pwdata[CTRL_BIT];
                OFS_SINGLE:
                begin
                    // writing 0 cannot cancel; only completion clears
                    if (pwdata[CTRL_BIT] && !state_reg.stream)
                        state_next.single = 1'b1;
                end
                default:    state_next.rdata = state_next.rdata;
            endcase
            for (int i = 0; i < NUM_FEAT; i++)
            begin
                if (paddr == FEAT_OFS[i])
                begin
                    if (ON_OFF_CAP[i])
                        state_next.on[i] = pwdata[FB_ON];
                    state_next.auto[i] = pwdata[FB_AUTO];
                    // mode held before this write decides whether value lands
                    if (!state_reg.auto[i])
                    begin
                        state_next.value[i*VAL_W +: VAL_W] = pwdata[VAL_MSB:VAL_LSB];
                        if (i == FI_BAL)
                            state_next.uValue = pwdata[U_MSB:U_LSB];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg.rate   <= RST_SEL;
            state_reg.mode   <= RST_SEL;
            state_reg.format <= RST_SEL;
            state_reg.chan   <= RST_CHAN;
            state_reg.speed  <= RST_SPEED;
            state_reg.power  <= RST_CTRL;
            state_reg.stream <= RST_CTRL;
            state_reg.single <= RST_CTRL;
            state_reg.on     <= {NUM_FEAT{RST_ON}};
            state_reg.auto   <= {NUM_FEAT{RST_AUTO}};
            state_reg.value  <= {NUM_FEAT{RST_VAL}};
            state_reg.uValue <= RST_VAL;
            state_reg.rdata  <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata         = state_reg.rdata;
    assign pready         = 1'b1;
    assign pslverr        = 1'b0;
    assign frameRate      = state_reg.rate;
    assign videoMode      = state_reg.mode;
    assign videoFormat    = state_reg.format;
    assign isoChannel     = state_reg.chan;
    assign isoSpeed       = state_reg.speed;
    assign sensorPower    = state_reg.power;
    assign streamEnable   = state_reg.stream;
    assign singleFrameReq = state_reg.single;
    assign featureOn      = state_reg.on;
    assign featureAuto    = state_reg.auto;
    assign featureValue   = state_reg.value;
    assign balanceU       = state_reg.uValue;

endmodule : ccr_register_bank

// ===== ccr_register_bank_chk.sv
// checker for the camera control register bank ports
// assumes bind from the bench top, one clock domain
`timescale 1ns/10ps
module ccr_register_bank_chk
    import ccr_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      nrst,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [ADDR_W-1:0]         paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      frameSent,
    input wire logic [2:0]                frameRate,
    input wire logic [3:0]                isoChannel,
    input wire logic [1:0]                isoSpeed,
    input wire logic                      sensorPower,
    input wire logic                      streamEnable,
    input wire logic                      singleFrameReq,
    input wire logic [NUM_FEAT-1:0]       featureAuto,
    input wire logic [NUM_FEAT*VAL_W-1:0] featureValue
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence wr_to(logic [ADDR_W-1:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence pending;
        singleFrameReq && !frameSent;
    endsequence
    chk_power_pin: assert property (wr_to(OFS_POWER) |=> sensorPower == $past(pwdata[31]))
        else $error("power pin not following write");
    chk_stream_run: assert property (wr_to(OFS_STREAM) |=> streamEnable == $past(pwdata[31]))
        else $error("stream enable not following write");
    chk_rate_sel: assert property (wr_to(OFS_RATE) |=> frameRate == $past(pwdata[31:29]))
        else $error("frame rate selector wrong");
    chk_chan_speed: assert property (wr_to(OFS_CHAN_SPEED) |=>
        {isoChannel, isoSpeed} == {$past(pwdata[31:28]), $past(pwdata[25:24])})
        else $error("channel or speed wrong");
    chk_single_ignore: assert property (wr_to(OFS_SINGLE) ##0 (streamEnable && !singleFrameReq)
        |=> !singleFrameReq) else $error("single frame taken while streaming");
    chk_single_clear: assert property (singleFrameReq && frameSent &&
        !(psel && penable && pwrite && paddr == OFS_SINGLE) |=> !singleFrameReq)
        else $error("single frame not cleared");
    chk_single_hold: assert property (pending |=> singleFrameReq)
        else $error("single frame dropped early");
    chk_auto_gate: assert property (wr_to(12'h800) ##0 featureAuto[0]
        |=> $stable(featureValue[11:0])) else $error("value written in auto mode");
endmodule : ccr_register_bank_chk

// ===== ccr_frame_source.sv
// video datapath stand-in: reports each frame sent
// assumes the bank's clock and reset
`timescale 1ns/10ps
module ccr_frame_source
#(
    parameter int FRAME_CYCLES = 8
)
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic singleFrameReq,
    input  wire logic streamEnable,
    output logic      frameSent
);
    int cnt;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt       <= 0;
            frameSent <= 1'b0;
        end
        else
        begin
            frameSent <= 1'b0;
            // one frame per request, free running while streaming
            if (singleFrameReq || streamEnable)
            begin
                cnt       <= (cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
                frameSent <= (cnt == FRAME_CYCLES - 1);
            end
            else
                cnt <= 0;
        end
    end
endmodule : ccr_frame_source

// ===== camera_control_register_bank_tb.sv
// self-checking bench for the camera control register bank
// assumes zero-wait apb slave and the frame source stand-in
`timescale 1ns/10ps
module camera_control_register_bank_tb;
    import ccr_pkg::*;
    typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r;} ccr_row_t;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, frameSent, sensorPower, streamEnable, singleFrameReq;
    logic [2:0] frameRate, videoMode, videoFormat;
    logic [3:0] isoChannel;
    logic [1:0] isoSpeed;
    logic [NUM_FEAT-1:0] featureOn, featureAuto;
    logic [NUM_FEAT*VAL_W-1:0] featureValue;
    logic [VAL_W-1:0] balanceU;
    int mismatches = 0, num_checks = 0, n;
    ccr_row_t rows [15] = '{
        '{12'h600, 32'hffffffff, 32'he0000000}, '{12'h604, 32'ha0000000, 32'ha0000000},
        '{12'h608, 32'h4fffffff, 32'h40000000}, '{12'h60c, 32'hffffffff, 32'hf3000000},
        '{12'h60c, 32'h82000000, 32'h82000000}, '{12'h610, 32'h80000000, 32'h80000000},
        '{12'h618, 32'hffffffff, 32'h00000000}, '{12'h620, 32'hffffffff, 32'h00000000},
        '{12'h800, 32'h00000abc, 32'h82000abc}, '{12'h80c, 32'h00123456, 32'h82123456},
        '{12'h508, 32'h00000fff, 32'h82000fff}, '{12'h580, 32'h00000001, 32'h02000001},
        '{12'h81c, 32'h00000007, 32'h82000007}, '{12'h82c, 32'hffffffff, 32'h00000000},
        '{12'h884, 32'hffffffff, 32'h00000000}};
    always #50 clk = ~clk;
    ccr_register_bank DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frameSent(frameSent), .frameRate(frameRate),
        .videoMode(videoMode), .videoFormat(videoFormat), .isoChannel(isoChannel),
        .isoSpeed(isoSpeed), .sensorPower(sensorPower), .streamEnable(streamEnable),
        .singleFrameReq(singleFrameReq), .featureOn(featureOn), .featureAuto(featureAuto),
        .featureValue(featureValue), .balanceU(balanceU));
    ccr_frame_source PART (.clk(clk), .nrst(nrst), .singleFrameReq(singleFrameReq),
        .streamEnable(streamEnable), .frameSent(frameSent));
    task automatic end_of_test;
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk
    // idle edge after each transfer so no strobe is assigned twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin mismatches++; end_of_test(); end
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("power", {31'h0, sensorPower}, 32'h0);
        chk("feat_on", {21'h0, featureOn}, 32'h7ff);
        apb(1'b0, 12'h800, 32'h0); chk("bright_rst", rd, 32'h82000000);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            // zoom is not present by default: its presence bit reads 0, while the on bit and the value read back as stored
            chk("row_read", rd, rows[i].r);
        end
        chk("pins", {22'h0, frameRate, isoChannel, isoSpeed, sensorPower}, {22'h0, 3'h7, 4'h8, 2'h2, 1'b1});
        chk("modes", {26'h0, videoMode, videoFormat}, {26'h0, 3'h5, 3'h2});
        chk("bal", {8'h0, balanceU, featureValue[47:36]}, {8'h0, 12'h123, 12'h456});
        chk("bus_resp", {30'h0, pready, pslverr}, 32'h2);
        apb(1'b1, 12'h800, 32'h01000555); apb(1'b1, 12'h800, 32'h01000123);
        apb(1'b0, 12'h800, 32'h0); chk("auto", rd, 32'h83000555);
        chk("auto_pin", {21'h0, featureAuto}, 32'h1);
        apb(1'b1, 12'h61c, 32'h80000000); chk("one", {31'h0, singleFrameReq}, 32'h1);
        n = 0;
        while (singleFrameReq === 1'b1 && n < 40) begin @(posedge clk); n++; end
        chk("one_clr", {31'h0, singleFrameReq}, 32'h0);
        apb(1'b1, 12'h614, 32'h80000000); chk("run", {31'h0, streamEnable}, 32'h1);
        apb(1'b1, 12'h61c, 32'h80000000); chk("ign", {31'h0, singleFrameReq}, 32'h0);
        apb(1'b1, 12'h614, 32'h0); chk("stop", {31'h0, streamEnable}, 32'h0);
        end_of_test();
    end
endmodule : camera_control_register_bank_tb
bind ccr_register_bank ccr_register_bank_chk CHK (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .frameSent(frameSent),
    .frameRate(frameRate), .isoChannel(isoChannel), .isoSpeed(isoSpeed),
    .sensorPower(sensorPower), .streamEnable(streamEnable), .singleFrameReq(singleFrameReq),
    .featureAuto(featureAuto), .featureValue(featureValue));
